// file: logic/dsq_pkg.sv
package dsq_pkg;

  localparam int unsigned CNT_W = 15;
  localparam int unsigned DIG_W = 8;

  // Phase lengths in converter counts, long (five decade) and short mode
  localparam logic [14:0] AZ_LONG  = 15'h2711;
  localparam logic [14:0] AZ_SHORT = 15'h03E9;
  localparam logic [14:0] SI_LONG  = 15'h2710;
  localparam logic [14:0] SI_SHORT = 15'h03E8;
  localparam logic [14:0] RI_LONG  = 15'h4E21;
  localparam logic [14:0] RI_SHORT = 15'h07D1;

  // Low-reading limits, 9 percent of range
  localparam logic [14:0] UNDER_LONG  = 15'h0708;
  localparam logic [14:0] UNDER_SHORT = 15'h00B4;

  // Digit scan timing
  localparam logic [7:0] DIGIT_LONG  = 8'hC8;
  localparam logic [7:0] DIGIT_SHORT = 8'h14;
  localparam logic [7:0] HALF_LONG   = 8'h64;
  localparam logic [7:0] HALF_SHORT  = 8'h0A;
  localparam logic [2:0] STROBES     = 3'h5;
  localparam logic [2:0] LAST_DIGIT  = 3'h4;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;

  // CTRL fields
  localparam int unsigned CTRL_LONG_BIT = 0;
  localparam int unsigned CTRL_RUN_BIT  = 1;
  localparam logic        CTRL_LONG_RST = 1'h1;
  localparam logic        CTRL_RUN_RST  = 1'h1;
  localparam int unsigned START_BIT     = 0;

  // STATUS fields
  localparam int unsigned ST_OVER_BIT  = 0;
  localparam int unsigned ST_UNDER_BIT = 1;
  localparam int unsigned ST_POL_BIT   = 2;
  localparam int unsigned ST_BUSY_BIT  = 3;
  localparam int unsigned ST_PHASE_LSB = 4;

  typedef enum logic [1:0] {
    PH_AUTO_ZERO = 2'h0,
    PH_SIGNAL    = 2'h1,
    PH_REFERENCE = 2'h2,
    PH_HOLD      = 2'h3
  } dsq_phase_type;

endpackage

// file: logic/dsq_bcd_counter.sv
`timescale 1ns/1ns
module dsq_bcd_counter #(
  parameter int unsigned DIGITS = 5
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_clear,
  input  wire logic                  i_inc,
  input  wire logic                  i_short,
  output logic      [4*DIGITS-1:0]   o_bcd
);

  logic [4*DIGITS-1:0] next_bcd;
  logic                carry;

  always_comb begin
    next_bcd = o_bcd;
    carry    = 1'h1;
    for (int i = 0; i < DIGITS; i++) begin
      if (i == 0 && i_short) begin
        // Lowest decade held clear, the count enters the next decade
        next_bcd[3:0] = 4'h0;
      end else if (carry) begin
        if (o_bcd[4*i +: 4] == 4'h9) begin
          next_bcd[4*i +: 4] = 4'h0;
        end else begin
          next_bcd[4*i +: 4] = o_bcd[4*i +: 4] + 4'h1;
          carry              = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      o_bcd <= '0;
    end else if (i_inc) begin
      o_bcd <= next_bcd;
    end
  end

endmodule

// file: logic/dsq_sequencer.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
module dsq_sequencer
  import dsq_pkg::*;
#(
  parameter logic [14:0] P_AZ_LONG = dsq_pkg::AZ_LONG,
  parameter logic [14:0] P_SI_LONG = dsq_pkg::SI_LONG,
  parameter logic [14:0] P_RI_LONG = dsq_pkg::RI_LONG
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_SRST,
  input  wire logic        I_CE,
  input  wire logic        I_COMP,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_AUTO_ZERO,
  output logic             O_SIGNAL_INTEGRATE,
  output logic             O_REF_INTEGRATE,
  output logic             O_BUSY,
  output logic             O_STROBE_N,
  output logic             O_OVER_RANGE,
  output logic             O_UNDER_RANGE,
  output logic             O_POLARITY,
  output logic             O_DIGIT_SELECT_MSD,
  output logic             O_DIGIT_SELECT_4,
  output logic             O_DIGIT_SELECT_3,
  output logic             O_DIGIT_SELECT_2,
  output logic             O_DIGIT_SELECT_LSD,
  output logic             O_BCD_WEIGHT_EIGHT,
  output logic             O_BCD_WEIGHT_FOUR,
  output logic             O_BCD_WEIGHT_TWO,
  output logic             O_BCD_WEIGHT_ONE
);

  import dsq_pkg::*;

  function automatic logic [14:0] pick15(input logic lng, input logic [14:0] a, input logic [14:0] b);
    return lng ? a : b;
  endfunction

  function automatic logic [7:0] pick8(input logic lng, input logic [7:0] a, input logic [7:0] b);
    return lng ? a : b;
  endfunction

  function automatic logic [3:0] digit_at(input logic [19:0] bcd, input logic [2:0] idx);
    case (idx)
      3'h0:    return bcd[19:16];
      3'h1:    return bcd[15:12];
      3'h2:    return bcd[11:8];
      3'h3:    return bcd[7:4];
      default: return bcd[3:0];
    endcase
  endfunction

  logic          comp_meta;
  logic          comp_sync;
  logic          long_mode;
  logic          run;
  logic          start_pend;
  dsq_phase_type phase;
  logic [14:0]   ph_cnt;
  logic [14:0]   ph_len;
  logic          phase_adv;
  logic          si_start;
  logic          ri_start;
  logic          cycle_end;
  logic          busy;
  logic          no_count;
  logic          ovl_pend;
  logic          end_busy;
  logic          zero_cross;
  logic          over_flag;
  logic          under_flag;
  logic          polarity;
  logic          cnt_inc;
  logic [14:0]   count_bin;
  logic [19:0]   count_bcd;
  logic [19:0]   result_bcd;
  logic [2:0]    dig_idx;
  logic [7:0]    dig_cnt;
  logic [7:0]    dig_len;
  logic [7:0]    strobe_pos;
  logic          first_dig;
  logic          blank;
  logic [2:0]    strobes_left;
  logic          strobe_n;
  logic          apb_wr;
  logic          mapped;

  // Comparator comes from the analog side, two flops before use
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      comp_meta <= 1'h0;
      comp_sync <= 1'h0;
    end else if (I_CE) begin
      comp_meta <= I_COMP;
      comp_sync <= comp_meta;
    end
  end

  // Phase sequencing
  always_comb begin
    case (phase)
      PH_AUTO_ZERO: ph_len = pick15(long_mode, P_AZ_LONG, AZ_SHORT);
      PH_SIGNAL:    ph_len = pick15(long_mode, P_SI_LONG, SI_SHORT);
      PH_REFERENCE: ph_len = pick15(long_mode, P_RI_LONG, RI_SHORT);
      default:      ph_len = 15'h0001;
    endcase
  end

  assign phase_adv = I_CE && (phase != PH_HOLD) && (ph_cnt == ph_len - 15'h0001);
  assign si_start  = phase_adv && (phase == PH_AUTO_ZERO);
  assign ri_start  = phase_adv && (phase == PH_SIGNAL);
  assign cycle_end = phase_adv && (phase == PH_REFERENCE);

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      phase  <= PH_AUTO_ZERO;
      ph_cnt <= 15'h0000;
    end else if (I_CE) begin
      case (phase)
        PH_AUTO_ZERO: begin
          ph_cnt <= phase_adv ? 15'h0000 : ph_cnt + 15'h0001;
          if (phase_adv) begin
            phase <= PH_SIGNAL;
          end
        end
        PH_SIGNAL: begin
          ph_cnt <= phase_adv ? 15'h0000 : ph_cnt + 15'h0001;
          if (phase_adv) begin
            phase <= PH_REFERENCE;
          end
        end
        PH_REFERENCE: begin
          ph_cnt <= phase_adv ? 15'h0000 : ph_cnt + 15'h0001;
          if (phase_adv) begin
            phase <= run ? PH_AUTO_ZERO : PH_HOLD;
          end
        end
        PH_HOLD: begin
          ph_cnt <= 15'h0000;
          if (run || start_pend) begin
            phase <= PH_AUTO_ZERO;
          end
        end
        default: begin
          phase  <= PH_AUTO_ZERO;
          ph_cnt <= 15'h0000;
        end
      endcase
    end
  end

  // A start request counts only once the cycle is complete
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      start_pend <= 1'h0;
    end else if (I_CE) begin
      if (phase != PH_HOLD) begin
        start_pend <= 1'h0;
      end else if (apb_wr && I_PADDR == ADDR_START && I_PWDATA[START_BIT]) begin
        start_pend <= 1'h1;
      end
    end
  end

  // Busy, zero crossing and overload
  assign zero_cross = busy && (phase == PH_REFERENCE) && !no_count && (comp_sync != polarity);

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      busy     <= 1'h0;
      no_count <= 1'h0;
      ovl_pend <= 1'h0;
      end_busy <= 1'h0;
    end else if (I_CE) begin
      end_busy <= 1'h0;
      no_count <= ri_start;
      if (si_start) begin
        busy     <= 1'h1;
        ovl_pend <= 1'h0;
      end else if (zero_cross) begin
        busy     <= 1'h0;
        end_busy <= 1'h1;
      end else if (cycle_end && busy) begin
        busy     <= 1'h0;
        end_busy <= 1'h1;
        ovl_pend <= 1'h1;
      end
    end
  end

  // The first reference count is dropped to offset the crossing detector delay
  assign cnt_inc = I_CE && (phase == PH_REFERENCE) && busy && !no_count;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST || (I_CE && ri_start)) begin
      count_bin <= 15'h0000;
    end else if (cnt_inc) begin
      count_bin <= count_bin + 15'h0001;
    end
  end

  dsq_bcd_counter #(
    .DIGITS (5)
  ) u_counter (
    .i_clk   (I_MCLK),
    .i_srst  (I_SRST),
    .i_clear (I_CE && ri_start),
    .i_inc   (cnt_inc),
    .i_short (!long_mode),
    .o_bcd   (count_bcd)
  );

  // Result latches and flags load in the first clock after busy falls
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      result_bcd <= 20'h0_0000;
      over_flag  <= 1'h0;
      under_flag <= 1'h0;
    end else if (I_CE) begin
      if (end_busy) begin
        result_bcd <= count_bcd;
        over_flag  <= ovl_pend;
        under_flag <= !ovl_pend && (count_bin <= pick15(long_mode, UNDER_LONG, UNDER_SHORT));
      end else begin
        if (ri_start) begin
          over_flag <= 1'h0;
        end
        if (si_start) begin
          under_flag <= 1'h0;
        end
      end
    end
  end

  // Sign of the integrated ramp, shown from reference integrate onward
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      polarity <= 1'h1;
    end else if (I_CE && ri_start) begin
      polarity <= comp_sync;
    end
  end

  // Digit scan and strobes
  assign dig_len    = pick8(long_mode, DIGIT_LONG, DIGIT_SHORT) + {7'h00, first_dig};
  assign strobe_pos = pick8(long_mode, HALF_LONG, HALF_SHORT) + {7'h00, first_dig};

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      dig_idx      <= 3'h0;
      dig_cnt      <= 8'h00;
      first_dig    <= 1'h0;
      blank        <= 1'h0;
      strobes_left <= 3'h0;
      strobe_n     <= 1'h1;
    end else if (I_CE) begin
      strobe_n <= 1'h1;
      if (ri_start && blank) begin
        blank   <= 1'h0;
        dig_idx <= 3'h0;
        dig_cnt <= 8'h00;
      end else if (cycle_end) begin
        dig_idx      <= 3'h0;
        dig_cnt      <= 8'h00;
        first_dig    <= 1'h1;
        strobes_left <= STROBES;
      end else if (!blank) begin
        if (dig_cnt == strobe_pos && strobes_left != 3'h0) begin
          strobe_n     <= 1'h0;
          strobes_left <= strobes_left - 3'h1;
        end
        if (dig_cnt == dig_len - 8'h01) begin
          dig_cnt   <= 8'h00;
          first_dig <= 1'h0;
          dig_idx   <= (dig_idx == LAST_DIGIT) ? 3'h0 : dig_idx + 3'h1;
          if (dig_idx == LAST_DIGIT && over_flag && strobes_left == 3'h0) begin
            blank <= 1'h1;
          end
        end else begin
          dig_cnt <= dig_cnt + 8'h01;
        end
      end
    end
  end

  // Select and data both decode blank and dig_idx, so they step together; data also changes when result_bcd loads
  assign O_DIGIT_SELECT_MSD = !blank && dig_idx == 3'h0;
  assign O_DIGIT_SELECT_4   = !blank && dig_idx == 3'h1;
  assign O_DIGIT_SELECT_3   = !blank && dig_idx == 3'h2;
  assign O_DIGIT_SELECT_2   = !blank && dig_idx == 3'h3;
  assign O_DIGIT_SELECT_LSD = !blank && dig_idx == 3'h4;

  assign {O_BCD_WEIGHT_EIGHT, O_BCD_WEIGHT_FOUR, O_BCD_WEIGHT_TWO, O_BCD_WEIGHT_ONE} =
    blank ? 4'h0 : digit_at(result_bcd, dig_idx);

  assign O_AUTO_ZERO        = (phase == PH_AUTO_ZERO) || (phase == PH_HOLD);
  assign O_SIGNAL_INTEGRATE = phase == PH_SIGNAL;
  assign O_REF_INTEGRATE    = phase == PH_REFERENCE;
  assign O_BUSY             = busy;
  assign O_STROBE_N         = strobe_n;
  assign O_OVER_RANGE       = over_flag;
  assign O_UNDER_RANGE      = under_flag;
  assign O_POLARITY         = polarity;

  // APB slave; the clock enable also stalls the bus so no access slips past a frozen block
  assign apb_wr    = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
  assign mapped    = (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_START) ||
                     (I_PADDR == ADDR_STATUS) || (I_PADDR == ADDR_RESULT);
  assign O_PREADY  = I_CE;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      long_mode <= CTRL_LONG_RST;
      run       <= CTRL_RUN_RST;
    end else if (apb_wr && I_PADDR == ADDR_CTRL) begin
      long_mode <= I_PWDATA[CTRL_LONG_BIT];
      run       <= I_PWDATA[CTRL_RUN_BIT];
    end
  end

  always_comb begin
    O_PRDATA = 32'h0000_0000;
    if (I_PSEL && !I_PWRITE) begin
      case (I_PADDR)
        ADDR_CTRL: begin
          O_PRDATA[CTRL_LONG_BIT] = long_mode;
          O_PRDATA[CTRL_RUN_BIT]  = run;
        end
        ADDR_STATUS: begin
          O_PRDATA[ST_OVER_BIT]                 = over_flag;
          O_PRDATA[ST_UNDER_BIT]                = under_flag;
          O_PRDATA[ST_POL_BIT]                  = polarity;
          O_PRDATA[ST_BUSY_BIT]                 = busy;
          O_PRDATA[ST_PHASE_LSB +: 2]           = phase;
        end
        ADDR_RESULT: O_PRDATA[19:0] = result_bcd;
        default:     O_PRDATA = 32'h0000_0000;
      endcase
    end
  end

endmodule

// file: verification/dsq_sequencer_asserts.sv
`timescale 1ns/1ns
module dsq_sequencer_asserts (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic O_SIGNAL_INTEGRATE,
  input wire logic O_REF_INTEGRATE,
  input wire logic O_BUSY,
  input wire logic O_STROBE_N,
  input wire logic O_OVER_RANGE,
  input wire logic O_UNDER_RANGE,
  input wire logic O_POLARITY,
  input wire logic O_DIGIT_SELECT_MSD,
  input wire logic O_DIGIT_SELECT_4,
  input wire logic O_DIGIT_SELECT_3,
  input wire logic O_DIGIT_SELECT_2,
  input wire logic O_DIGIT_SELECT_LSD,
  input wire logic O_BCD_WEIGHT_EIGHT,
  input wire logic O_BCD_WEIGHT_FOUR,
  input wire logic O_BCD_WEIGHT_TWO,
  input wire logic O_BCD_WEIGHT_ONE
);
  logic [4:0] sel;
  logic [3:0] bcd;
  assign sel = {O_DIGIT_SELECT_MSD, O_DIGIT_SELECT_4, O_DIGIT_SELECT_3, O_DIGIT_SELECT_2, O_DIGIT_SELECT_LSD};
  assign bcd = {O_BCD_WEIGHT_EIGHT, O_BCD_WEIGHT_FOUR, O_BCD_WEIGHT_TWO, O_BCD_WEIGHT_ONE};
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  sequence s_strobe; $fell(O_STROBE_N); endsequence
  sequence s_quiet; ($stable(sel) && O_STROBE_N)[*8]; endsequence
  sequence s_flag_set; $rose(O_OVER_RANGE) || $rose(O_UNDER_RANGE); endsequence
  sequence s_busy_end; $past(O_BUSY, 2) && !$past(O_BUSY); endsequence
  // End of reference restarts the scan, so steps are only judged away from that edge
  AST_SCAN_STEP: assert property ($changed(sel) && !($past(sel) inside {5'h00, 5'h01}) && !$changed(O_REF_INTEGRATE)
    |-> sel == ($past(sel) >> 1)) else $error("digit scan out of order");
  AST_SCAN_WRAP: assert property ($fell(O_DIGIT_SELECT_LSD) && !O_OVER_RANGE |-> O_DIGIT_SELECT_MSD)
    else $error("scan did not wrap to msd");
  AST_ONE_DIGIT: assert property ($onehot0(sel)) else $error("two digits selected");
  AST_BCD_BLANK: assert property (sel == 5'h00 |-> bcd == 4'h0) else $error("bcd without digit");
  AST_STROBE_MID: assert property (s_strobe |-> sel != 5'h00 && $past(sel, 8) == sel ##1 s_quiet)
    else $error("strobe not inside a digit");
  AST_OVER_CLEAR: assert property ($rose(O_REF_INTEGRATE) |-> !O_OVER_RANGE) else $error("over not cleared");
  AST_UNDER_CLEAR: assert property ($rose(O_SIGNAL_INTEGRATE) |-> !O_UNDER_RANGE && O_BUSY)
    else $error("under not cleared or busy low");
  AST_FLAG_LOAD: assert property (s_flag_set |-> s_busy_end) else $error("flag set off busy end");
  AST_FLAGS_EXCL: assert property (!(O_OVER_RANGE && O_UNDER_RANGE)) else $error("over and under both set");
  AST_POL_HOLD: assert property ($changed(O_POLARITY) |-> $rose(O_REF_INTEGRATE))
    else $error("polarity moved off reference start");
  AST_BLANK_RESTART: assert property ($rose(O_REF_INTEGRATE) && $past(sel) == 5'h00 |-> sel == 5'h10)
    else $error("scan did not restart at msd");
  AST_BUSY_END: assert property ($fell(O_BUSY) |-> $past(O_REF_INTEGRATE) || $past(O_REF_INTEGRATE, 2))
    else $error("busy ended outside reference");
endmodule

bind dsq_sequencer dsq_sequencer_asserts u_chk (.I_MCLK, .I_SRST, .O_SIGNAL_INTEGRATE, .O_REF_INTEGRATE, .O_BUSY,
  .O_STROBE_N, .O_OVER_RANGE, .O_UNDER_RANGE, .O_POLARITY, .O_DIGIT_SELECT_MSD, .O_DIGIT_SELECT_4,
  .O_DIGIT_SELECT_3, .O_DIGIT_SELECT_2, .O_DIGIT_SELECT_LSD, .O_BCD_WEIGHT_EIGHT, .O_BCD_WEIGHT_FOUR,
  .O_BCD_WEIGHT_TWO, .O_BCD_WEIGHT_ONE);

// file: verification/dsq_display_latch.sv
`timescale 1ns/1ns
module dsq_display_latch #(
  parameter int P_DELAY_COUNTS = 0
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_strobe_n,
  input  wire logic [4:0]  i_select,
  input  wire logic [3:0]  i_bcd,
  output logic      [19:0] o_word,
  output logic      [7:0]  o_strobes,
  output int               o_value
);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_strobes <= 8'h00;
    end else if (!i_strobe_n) begin
      o_strobes <= o_strobes + 8'h01;
    end
  end
  // Taken mid-pulse on the strobe, away from the edges where select and BCD change
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!i_strobe_n && i_select[i]) begin
        o_word[4*i +: 4] <= i_bcd;
      end
    end
  end
  // Fixed comparator overshoot is taken off each reading
  always_comb begin
    o_value = 0;
    for (int i = 4; i >= 0; i--) begin
      o_value = o_value * 10 + int'(o_word[4*i +: 4]);
    end
    o_value = o_value - P_DELAY_COUNTS;
  end
endmodule

// file: verification/dual_slope_result_output_sequencer_bench.sv
`timescale 1ns/1ns
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", w, e, g); end end
module dual_slope_result_output_sequencer_bench;
  import dsq_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        comp = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, az, si, ri, busy, stb_n, ovr, und, pol;
  logic [4:0]  sel;
  logic [3:0]  bcd;
  logic [19:0] word;
  logic [7:0]  nstb;
  int          val;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // Count enable dropped only inside a scan; a slower count source would fit whole mains periods
  dsq_sequencer #(.P_AZ_LONG(15'h001E), .P_SI_LONG(15'h0014), .P_RI_LONG(15'h0032)) u_dut (
    .I_MCLK(clk), .I_SRST(srst), .I_CE(ce), .I_COMP(comp), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_AUTO_ZERO(az), .O_SIGNAL_INTEGRATE(si), .O_REF_INTEGRATE(ri), .O_BUSY(busy),
    .O_STROBE_N(stb_n), .O_OVER_RANGE(ovr), .O_UNDER_RANGE(und), .O_POLARITY(pol),
    .O_DIGIT_SELECT_MSD(sel[4]), .O_DIGIT_SELECT_4(sel[3]), .O_DIGIT_SELECT_3(sel[2]),
    .O_DIGIT_SELECT_2(sel[1]), .O_DIGIT_SELECT_LSD(sel[0]), .O_BCD_WEIGHT_EIGHT(bcd[3]),
    .O_BCD_WEIGHT_FOUR(bcd[2]), .O_BCD_WEIGHT_TWO(bcd[1]), .O_BCD_WEIGHT_ONE(bcd[0]));

  dsq_display_latch u_latch (.i_clk(clk), .i_srst(srst), .i_strobe_n(stb_n), .i_select(sel), .i_bcd(bcd),
    .o_word(word), .o_strobes(nstb), .o_value(val));

  always #4 clk = ~clk;

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Runs about 6400 cycles, just under a third of this; the rest is margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_scan(input int dlen, input logic blank, input int hold_n);
    int         n, s, p;
    logic [4:0] want;
    logic [7:0] c0;
    c0 = nstb;
    while (ri !== 1'b1) @(posedge clk);
    while (ri !== 1'b0) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      want = 5'h10 >> k;
      n = 0;
      s = 0;
      p = 0;
      while (sel === want) begin
        n++;
        if (stb_n === 1'b0) begin
          s++;
          p = n;
        end
        // Freeze early in the first digit; the digit must stretch by exactly the frozen edges
        if (k == 0 && hold_n > 0 && n == 2) begin
          ce <= 1'b0;
        end
        if (k == 0 && hold_n > 0 && n == 2 + hold_n) begin
          ce <= 1'b1;
        end
        @(posedge clk);
      end
      `CHK("digit length", dlen + int'(k == 0) + ((k == 0) ? hold_n : 0), n)
      `CHK("strobes in digit", 1, s)
      p = p - ((k == 0) ? hold_n : 0);
      `CHK("strobe centred", 1'b1, (p >= dlen / 2 - 2) && (p <= dlen / 2 + 3))
    end
    `CHK("after scan", blank ? 5'h00 : 5'h10, sel)
    `CHK("strobe count", 8'h05, 8'(nstb - c0))
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    @(posedge clk);
    `CHK("reset state", {6'b101001, 5'h10, 4'h0}, {az, busy, stb_n, ovr, und, pol, sel, bcd})
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, r, e);
    `CHK("ctrl reset", 32'h0000_0003, r)
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    `CHK("unmapped", 33'h1_0000_0000, {e, r})
  endtask

  // Comparator never crosses, so the first reading runs out of range
  task automatic t_overload();
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_CTRL, 32'h0000_0001, r, e);
    check_scan(200, 1'b1, 0);
    `CHK("overload flags", 2'b10, {ovr, und})
    repeat (20) @(posedge clk);
    `CHK("blanked", 9'h000, {sel, bcd})
    apb(1'b0, ADDR_STATUS, 32'h0000_0000, r, e);
    `CHK("status", 6'h35, r[5:0])
  endtask

  task automatic t_measure(input logic [31:0] ctrl, input logic p_in, input int az_n, si_n, cut, lo, hi, dlen);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, ADDR_CTRL, ctrl, r, e);
    apb(1'b1, ADDR_START, 32'h0000_0001, r, e);
    n = 0;
    while (si !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    // Two held edges come first: one takes the start, one leaves hold
    `CHK("auto-zero counts", az_n + 2, n)
    `CHK("busy and under at signal", 2'b10, {busy, und})
    comp <= p_in;
    n = 0;
    while (si === 1'b1) begin
      n++;
      @(posedge clk);
    end
    `CHK("signal counts", si_n, n)
    `CHK("polarity", p_in, pol)
    `CHK("over at reference", 1'b0, ovr)
    repeat (cut) @(posedge clk);
    comp <= ~p_in;
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK("flags", 2'b01, {ovr, und})
    apb(1'b0, ADDR_RESULT, 32'h0000_0000, r, e);
    check_scan(dlen, 1'b0, 7);
    `CHK("latched digits", r[19:0], word)
    `CHK("reading", 1'b1, (val >= lo) && (val <= hi))
    `CHK("low decade", 1'b1, ctrl[0] || (r[3:0] === 4'h0))
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_overload();
    t_measure(32'h0000_0001, 1'b0, 30, 20, 10, 7, 15, 200);
    t_measure(32'h0000_0000, 1'b1, 1001, 1000, 30, 280, 340, 20);
    tally_and_finish();
  end
endmodule
